// >>> rtl/ipw_pkg.sv
// Purpose: Shared constants and carriers for the identify parameter word block
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: Word numbers and fixed field values of the 256-word identify block
package ipw_pkg;

    // Register byte offsets
    localparam logic [7:0] IPW_OFF_CTRL = 8'h00;
    localparam logic [7:0] IPW_OFF_STATUS = 8'h04;
    localparam logic [7:0] IPW_OFF_DATA = 8'h08;
    localparam logic [7:0] IPW_OFF_CUR_CHS = 8'h0C;
    localparam logic [7:0] IPW_OFF_MODES = 8'h10;

    // Control register bits
    localparam int IPW_CTRL_START = 0;
    localparam int IPW_CTRL_ALT_LOW = 1;
    localparam int IPW_CTRL_STANDBY = 2;
    localparam int IPW_CTRL_IORDY = 3;

    // Register field positions
    localparam int IPW_STAT_XFER = 16;
    localparam int IPW_CHS_HEADS_LSB = 16;
    localparam int IPW_CHS_SPT_LSB = 24;
    localparam int IPW_MODES_DMA_LSB = 16;
    localparam int IPW_MODES_PIO_LSB = 18;
    localparam int IPW_DMA_SEL_LSB = 8;
    localparam int IPW_DMA_MODES = 3;

    // Identify word numbers
    localparam logic [7:0] IPW_W_CONFIG = 8'h00;
    localparam logic [7:0] IPW_W_DEF_CYL = 8'h01;
    localparam logic [7:0] IPW_W_DEF_HEADS = 8'h03;
    localparam logic [7:0] IPW_W_DEF_SPT = 8'h06;
    localparam logic [7:0] IPW_W_CAP_MSW = 8'h07;
    localparam logic [7:0] IPW_W_CAP_LSW = 8'h08;
    localparam logic [7:0] IPW_W_SERIAL_LO = 8'h0A;
    localparam logic [7:0] IPW_W_SERIAL_HI = 8'h13;
    localparam logic [7:0] IPW_W_ECC = 8'h16;
    localparam logic [7:0] IPW_W_FW_LO = 8'h17;
    localparam logic [7:0] IPW_W_FW_HI = 8'h1A;
    localparam logic [7:0] IPW_W_MODEL_LO = 8'h1B;
    localparam logic [7:0] IPW_W_MODEL_HI = 8'h2E;
    localparam logic [7:0] IPW_W_MULT_MAX = 8'h2F;
    localparam logic [7:0] IPW_W_CAPS = 8'h31;
    localparam logic [7:0] IPW_W_PIO = 8'h33;
    localparam logic [7:0] IPW_W_VALID = 8'h35;
    localparam logic [7:0] IPW_W_CUR_CYL = 8'h36;
    localparam logic [7:0] IPW_W_CUR_HEADS = 8'h37;
    localparam logic [7:0] IPW_W_CUR_SPT = 8'h38;
    localparam logic [7:0] IPW_W_CUR_CAP_LSW = 8'h39;
    localparam logic [7:0] IPW_W_CUR_CAP_MSW = 8'h3A;
    localparam logic [7:0] IPW_W_MULT_SET = 8'h3B;
    localparam logic [7:0] IPW_W_LBA_LSW = 8'h3C;
    localparam logic [7:0] IPW_W_LBA_MSW = 8'h3D;
    localparam logic [7:0] IPW_W_DMA = 8'h3F;
    localparam logic [7:0] IPW_W_LAST = 8'hFF;

    // Fixed field values
    localparam logic [5:0] IPW_CFG_LOW_PREF = 6'h00;
    localparam logic [5:0] IPW_CFG_LOW_ALT = 6'h0A;
    localparam logic [15:0] IPW_ECC_COUNT = 16'h0004;
    localparam logic [7:0] IPW_MULT_HI = 8'h80;
    localparam logic [7:0] IPW_MULT_VALID = 8'h01;
    localparam logic [7:0] IPW_SPACE = 8'h20;
    localparam logic [1:0] IPW_PIO_MAX = 2'h2;
    localparam logic [1:0] IPW_DMA_NONE = 2'h3;
    localparam int IPW_CAP_STANDBY = 13;
    localparam int IPW_CAP_IORDY = 11;
    localparam int IPW_CAP_IORDY_DIS = 10;
    localparam int IPW_CAP_LBA = 9;
    localparam int IPW_CAP_DMA = 8;

    // Transfer state of the data port
    typedef enum logic [0:0] {
        IPW_IDLE = 1'b0,
        IPW_SEND = 1'b1
    } ipw_xfer_e;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ipw_avm_req_s;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ipw_avm_rsp_s;

    // Whole state of the block
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        ipw_xfer_e xfer;
        logic [7:0] idx;
        logic alt_low;
        logic standby_std;
        logic iordy_sup;
        logic [15:0] cur_cyl;
        logic [7:0] cur_heads;
        logic [7:0] cur_spt;
        logic [7:0] mult_cur;
        logic [1:0] dma_sel;
        logic [1:0] pio_mode;
    } ipw_state_s;

endpackage

// >>> rtl/ipw_identify.sv
// Purpose: Identify-device parameter block served word by word over Avalon-MM
// Assumes: One clock, asynchronous active-high reset, master holds requests
// Notes: Geometry, strings and limits are parameters; active settings are registers
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
module ipw_identify #(
    parameter logic [15:0] CFG_HIGH = 16'h0040, // Arbitrary value, upper config bits
    parameter logic [15:0] DEF_CYL = 16'h0100,
    parameter logic [7:0] DEF_HEADS = 8'h10,
    parameter logic [7:0] DEF_SPT = 8'h3F,
    parameter logic [7:0] MULT_MAX = 8'h01,
    parameter logic [1:0] DMA_MAX = 2'h2,
    parameter logic ADV_PIO = 1'b0,
    parameter logic [159:0] SERIAL_TEXT = "SN0000000001",
    parameter logic [63:0] FW_TEXT = "REV1",
    parameter logic [319:0] MODEL_TEXT = "FLASH STORAGE CARD"
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire ipw_pkg::ipw_avm_req_s avm_req,
    output ipw_pkg::ipw_avm_rsp_s avm_rsp
);
    import ipw_pkg::*;

    // Replace leading zero bytes by spaces, leaving text right-aligned
    function automatic logic [319:0] pad_right_align(input logic [319:0] t, input int n);
        logic [319:0] r;
        logic lead;
        r = t;
        lead = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            if (lead && r[i*8 +: 8] == 8'h00) begin
                r[i*8 +: 8] = IPW_SPACE;
            end else begin
                lead = 1'b0;
            end
        end
        return r;
    endfunction

    // Shift text to the top and fill the tail with spaces
    function automatic logic [319:0] pad_left_align(input logic [319:0] t, input int n);
        logic [319:0] r;
        int lead;
        r = t;
        lead = 0;
        for (int i = n - 1; i >= 0; i--) begin
            if (r[i*8 +: 8] == 8'h00 && lead == n - 1 - i) begin
                lead = lead + 1;
            end
        end
        r = r << (lead * 8);
        for (int i = 0; i < n; i++) begin
            if (i < lead) begin
                r[i*8 +: 8] = IPW_SPACE;
            end
        end
        return r;
    endfunction

    localparam logic [319:0] SERIAL_PAD = pad_right_align({160'h0, SERIAL_TEXT}, 20);
    localparam logic [319:0] FW_PAD = pad_left_align({256'h0, FW_TEXT}, 8);
    localparam logic [319:0] MODEL_PAD = pad_left_align(MODEL_TEXT, 40);
    localparam logic [31:0] TOTAL_SECT = 32'(DEF_CYL * DEF_HEADS * DEF_SPT);

    ipw_state_s q;
    ipw_state_s d;
    logic [31:0] cur_cap;
    logic [15:0] cur_word;
    logic [31:0] reg_rd;
    logic [31:0] wr_merged;

    // Current capacity follows the active translation
    assign cur_cap = 32'(q.cur_cyl * q.cur_heads * q.cur_spt);

    // One identify word selected by number
    function automatic logic [15:0] ident_word(input ipw_state_s s, input logic [31:0] cap,
                                               input logic [7:0] n);
        logic [15:0] w;
        logic [7:0] k;
        w = 16'h0000;
        k = 8'h00;
        case (n)
            IPW_W_CONFIG: begin
                w = {CFG_HIGH[15:6], s.alt_low ? IPW_CFG_LOW_ALT : IPW_CFG_LOW_PREF};
                w[2] = 1'b0;
                w[0] = 1'b0;
            end
            IPW_W_DEF_CYL: w = DEF_CYL;
            IPW_W_DEF_HEADS: w = {8'h00, DEF_HEADS};
            IPW_W_DEF_SPT: w = {8'h00, DEF_SPT};
            IPW_W_CAP_MSW: w = TOTAL_SECT[31:16];
            IPW_W_CAP_LSW: w = TOTAL_SECT[15:0];
            IPW_W_ECC: w = IPW_ECC_COUNT;
            IPW_W_MULT_MAX: w = {IPW_MULT_HI, MULT_MAX};
            IPW_W_CAPS: begin
                w[IPW_CAP_STANDBY] = s.standby_std;
                w[IPW_CAP_IORDY] = s.iordy_sup;
                w[IPW_CAP_IORDY_DIS] = 1'b0;
                w[IPW_CAP_LBA] = 1'b1;
                w[IPW_CAP_DMA] = 1'b0;
            end
            IPW_W_PIO: w = {6'h00, s.pio_mode, 8'h00};
            IPW_W_VALID: w = {14'h0000, ADV_PIO, 1'b1};
            IPW_W_CUR_CYL: w = s.cur_cyl;
            IPW_W_CUR_HEADS: w = {8'h00, s.cur_heads};
            IPW_W_CUR_SPT: w = {8'h00, s.cur_spt};
            IPW_W_CUR_CAP_LSW: w = cap[15:0];
            IPW_W_CUR_CAP_MSW: w = cap[31:16];
            IPW_W_MULT_SET: w = {7'h00, 1'b1, s.mult_cur};
            IPW_W_LBA_LSW: w = TOTAL_SECT[15:0];
            IPW_W_LBA_MSW: w = TOTAL_SECT[31:16];
            IPW_W_DMA: begin
                // Selection one-hot, support cumulative, modes above 2 absent
                if (s.dma_sel != IPW_DMA_NONE) begin
                    w[IPW_DMA_SEL_LSB + 32'(s.dma_sel)] = 1'b1;
                end
                for (int i = 0; i < IPW_DMA_MODES; i++) begin
                    w[i] = (2'(i) <= DMA_MAX);
                end
            end
            default: begin
                if (n >= IPW_W_SERIAL_LO && n <= IPW_W_SERIAL_HI) begin
                    k = n - IPW_W_SERIAL_LO;
                    w = SERIAL_PAD[159 - 16 * k -: 16];
                end else if (n >= IPW_W_FW_LO && n <= IPW_W_FW_HI) begin
                    k = n - IPW_W_FW_LO;
                    w = FW_PAD[63 - 16 * k -: 16];
                end else if (n >= IPW_W_MODEL_LO && n <= IPW_W_MODEL_HI) begin
                    k = n - IPW_W_MODEL_LO;
                    w = MODEL_PAD[319 - 16 * k -: 16];
                end
            end
        endcase
        return w;
    endfunction

    // Word under the data port pointer
    assign cur_word = ident_word(q, cur_cap, q.idx);

    // Register read image
    always_comb begin
        reg_rd = 32'h0000_0000;
        case (avm_req.address)
            IPW_OFF_CTRL: begin
                reg_rd[IPW_CTRL_ALT_LOW] = q.alt_low;
                reg_rd[IPW_CTRL_STANDBY] = q.standby_std;
                reg_rd[IPW_CTRL_IORDY] = q.iordy_sup;
            end
            IPW_OFF_STATUS: begin
                reg_rd[7:0] = q.idx;
                reg_rd[IPW_STAT_XFER] = (q.xfer == IPW_SEND);
            end
            IPW_OFF_DATA: reg_rd[15:0] = (q.xfer == IPW_SEND) ? cur_word : 16'h0000;
            IPW_OFF_CUR_CHS: begin
                reg_rd[15:0] = q.cur_cyl;
                reg_rd[IPW_CHS_HEADS_LSB +: 8] = q.cur_heads;
                reg_rd[IPW_CHS_SPT_LSB +: 8] = q.cur_spt;
            end
            IPW_OFF_MODES: begin
                reg_rd[7:0] = q.mult_cur;
                reg_rd[IPW_MODES_DMA_LSB +: 2] = q.dma_sel;
                reg_rd[IPW_MODES_PIO_LSB +: 2] = q.pio_mode;
            end
            default: reg_rd = 32'h0000_0000;
        endcase
    end

    // Byte-lane merge of write data into the register image
    always_comb begin
        wr_merged = reg_rd;
        for (int b = 0; b < 4; b++) begin
            if (avm_req.byteenable[b]) begin
                wr_merged[b*8 +: 8] = avm_req.writedata[b*8 +: 8];
            end
        end
    end

    // Next-state logic: bus handshake, register writes, data port walk
    always_comb begin
        d = q;
        d.waitreq = 1'b1;
        if (avm_req.read || avm_req.write) begin
            if (q.waitreq) begin
                // Answer cycle: drop waitrequest with data ready
                d.waitreq = 1'b0;
                if (avm_req.read) begin
                    d.rdata = reg_rd;
                end
            end else if (avm_req.write) begin
                // Write takes effect at the accepting edge
                case (avm_req.address)
                    IPW_OFF_CTRL: begin
                        d.alt_low = wr_merged[IPW_CTRL_ALT_LOW];
                        d.standby_std = wr_merged[IPW_CTRL_STANDBY];
                        d.iordy_sup = wr_merged[IPW_CTRL_IORDY];
                        if (wr_merged[IPW_CTRL_START]) begin
                            d.xfer = IPW_SEND;
                            d.idx = IPW_W_CONFIG;
                        end
                    end
                    IPW_OFF_CUR_CHS: begin
                        d.cur_cyl = wr_merged[15:0];
                        d.cur_heads = wr_merged[IPW_CHS_HEADS_LSB +: 8];
                        d.cur_spt = wr_merged[IPW_CHS_SPT_LSB +: 8];
                    end
                    IPW_OFF_MODES: begin
                        if (wr_merged[7:0] <= MULT_MAX) begin
                            d.mult_cur = wr_merged[7:0];
                        end
                        if (wr_merged[IPW_MODES_DMA_LSB +: 2] <= DMA_MAX ||
                            wr_merged[IPW_MODES_DMA_LSB +: 2] == IPW_DMA_NONE) begin
                            d.dma_sel = wr_merged[IPW_MODES_DMA_LSB +: 2];
                        end
                        if (wr_merged[IPW_MODES_PIO_LSB +: 2] <= IPW_PIO_MAX) begin
                            d.pio_mode = wr_merged[IPW_MODES_PIO_LSB +: 2];
                        end
                    end
                    default: d.rdata = q.rdata;
                endcase
            end else if (avm_req.address == IPW_OFF_DATA) begin
                // Data port read steps through the block in order
                case (q.xfer)
                    IPW_SEND: begin
                        d.idx = q.idx + 8'h01;
                        if (q.idx == IPW_W_LAST) begin
                            d.xfer = IPW_IDLE;
                        end
                    end
                    IPW_IDLE: d.idx = q.idx;
                    default: d.xfer = IPW_IDLE;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            q <= '{waitreq: 1'b1, rdata: 32'h0000_0000, xfer: IPW_IDLE, idx: 8'h00,
                   alt_low: 1'b0, standby_std: 1'b0, iordy_sup: 1'b1,
                   cur_cyl: DEF_CYL, cur_heads: DEF_HEADS, cur_spt: DEF_SPT,
                   mult_cur: 8'h00, dma_sel: IPW_DMA_NONE, pio_mode: 2'h0};
        end else begin
            q <= d;
        end
    end

    assign avm_rsp.readdata = q.rdata;
    assign avm_rsp.waitrequest = q.waitreq;

    // Helper views for checks
    logic [15:0] w_cfg;
    logic [15:0] w_caps;
    logic [15:0] w_dma;
    logic [15:0] w_mult;
    logic [15:0] w_valid;
    logic acc_data_rd;
    assign w_cfg = ident_word(q, cur_cap, IPW_W_CONFIG);
    assign w_caps = ident_word(q, cur_cap, IPW_W_CAPS);
    assign w_dma = ident_word(q, cur_cap, IPW_W_DMA);
    assign w_mult = ident_word(q, cur_cap, IPW_W_MULT_SET);
    assign w_valid = ident_word(q, cur_cap, IPW_W_VALID);
    assign acc_data_rd = avm_req.read && !q.waitreq && avm_req.address == IPW_OFF_DATA;

    // Data port read seen at the edge that loads its answer
    logic data_ask;
    assign data_ask = avm_req.read && q.waitreq && avm_req.address == IPW_OFF_DATA
        && q.xfer == IPW_SEND;

    sequence s_req_seen;
        (avm_req.read || avm_req.write) && q.waitreq;
    endsequence

    sequence s_data_taken;
        acc_data_rd && q.xfer == IPW_SEND && q.idx != IPW_W_LAST;
    endsequence

    a_cfg_low_bits: assert property (@(posedge ref_clk) disable iff (reset)
        w_cfg[2] == 1'b0 && w_cfg[0] == 1'b0)
        else $error("config bit 2 or bit 0 set");

    a_cfg_pattern: assert property (@(posedge ref_clk) disable iff (reset)
        w_cfg[5:0] == IPW_CFG_LOW_PREF || w_cfg[5:0] == IPW_CFG_LOW_ALT)
        else $error("config low bits not 00h or 0Ah");

    a_ecc_word: assert property (@(posedge ref_clk) disable iff (reset)
        q.xfer == IPW_SEND && q.idx == IPW_W_ECC |-> cur_word == IPW_ECC_COUNT)
        else $error("ECC count word wrong");

    a_caps_fixed: assert property (@(posedge ref_clk) disable iff (reset)
        w_caps[10:8] == 3'h2 && w_caps[IPW_CAP_IORDY] == q.iordy_sup)
        else $error("capability bits 10-8 wrong");

    a_dma_onehot: assert property (@(posedge ref_clk) disable iff (reset)
        $countones(w_dma[15:8]) <= 1 && w_dma[15:11] == 5'h00)
        else $error("DMA selection not one-hot");

    a_mult_valid: assert property (@(posedge ref_clk) disable iff (reset)
        w_mult[15:8] == IPW_MULT_VALID && w_mult[7:0] == q.mult_cur)
        else $error("multiple setting word malformed");

    a_valid_bit: assert property (@(posedge ref_clk) disable iff (reset)
        w_valid[0] == 1'b1)
        else $error("field validity bit 0 clear");

    a_bus_answer: assert property (@(posedge ref_clk) disable iff (reset)
        s_req_seen |=> !avm_rsp.waitrequest ##1 avm_rsp.waitrequest)
        else $error("waitrequest did not pulse low for one cycle");

    a_word_order: assert property (@(posedge ref_clk) disable iff (reset)
        s_data_taken |=> q.idx == $past(q.idx) + 8'h01 && q.xfer == IPW_SEND)
        else $error("data port did not advance by one word");

    a_block_end: assert property (@(posedge ref_clk) disable iff (reset)
        acc_data_rd && q.xfer == IPW_SEND && q.idx == IPW_W_LAST |=> q.xfer == IPW_IDLE)
        else $error("transfer did not end after word 255");

    a_ecc_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_ECC |=> avm_rsp.readdata == {16'h0000, IPW_ECC_COUNT})
        else $error("ECC count word wrong on the bus");

    a_mult_hi_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_MULT_MAX |=> avm_rsp.readdata[15:8] == IPW_MULT_HI)
        else $error("maximum multiple word upper byte wrong");

    a_standby_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_CAPS |=> avm_rsp.readdata[IPW_CAP_STANDBY] == q.standby_std)
        else $error("standby timer bit does not follow setting");

    a_iordy_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_CAPS |=> avm_rsp.readdata[IPW_CAP_IORDY] == q.iordy_sup)
        else $error("IORDY support bit does not follow setting");

    a_caps_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_CAPS |=> avm_rsp.readdata[IPW_CAP_LBA] == 1'b1
        && avm_rsp.readdata[IPW_CAP_IORDY_DIS] == 1'b0)
        else $error("LBA or IORDY disable bit wrong on the bus");

    a_no_dma_cmd: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_CAPS |=> avm_rsp.readdata[IPW_CAP_DMA] == 1'b0)
        else $error("plain DMA command bit set");

    a_pio_range: assert property (@(posedge ref_clk) disable iff (reset)
        q.pio_mode <= IPW_PIO_MAX)
        else $error("PIO mode above 2 accepted");

    a_cur_cap_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_CUR_CAP_LSW |=> avm_rsp.readdata[15:0]
        == 16'(q.cur_cyl * q.cur_heads * q.cur_spt))
        else $error("current capacity low word is not the product");

    a_mult_set_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_MULT_SET |=> avm_rsp.readdata[15:8] == IPW_MULT_VALID)
        else $error("multiple setting valid byte wrong on the bus");

    a_lba_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_LBA_MSW |=> avm_rsp.readdata[15:0] == TOTAL_SECT[31:16])
        else $error("LBA total high word wrong");

    a_dma_sup_out: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx == IPW_W_DMA |=> avm_rsp.readdata[7:3] == 5'h00
        && avm_rsp.readdata[0] == 1'b1)
        else $error("DMA support byte wrong");

    a_tail_zero: assert property (@(posedge ref_clk) disable iff (reset)
        data_ask && q.idx > IPW_W_DMA |=> avm_rsp.readdata == 32'h0000_0000)
        else $error("word above 63 not zero");

endmodule

// >>> tb/ipw_host_model.sv
// Purpose: Host-side model that issues Avalon-MM accesses to the identify block
// Assumes: Accesses start after reset release; one access at a time
// Notes: Released lines carry inverted values so stale data cannot pass for fresh
`timescale 1ns/1ns
module ipw_host_model (
    input wire logic ref_clk,
    input wire ipw_pkg::ipw_avm_rsp_s avm_rsp,
    output ipw_pkg::ipw_avm_req_s avm_req
);
    import ipw_pkg::*;

    // Quiet bus at time zero
    initial begin
        avm_req = '0;
        avm_req.byteenable = 4'hF;
    end

    // One access: raise, hold until waitrequest low, take data, release
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge ref_clk);
        avm_req.address <= adr;
        avm_req.writedata <= wd;
        avm_req.write <= wr;
        avm_req.read <= ~wr;
        do @(posedge ref_clk); while (avm_rsp.waitrequest !== 1'b0);
        rd = avm_rsp.readdata;
        avm_req.read <= 1'b0;
        avm_req.write <= 1'b0;
        avm_req.address <= ~adr;
        avm_req.writedata <= ~wd;
    endtask
endmodule

// >>> tb/test_identify_parameter_words.sv
// Purpose: Self-checking bench reading the identify block word by word
// Assumes: Host model performs every bus access; expectations built here
// Notes: Firmware words are expected left-aligned with trailing spaces
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end
module test_identify_parameter_words;
    import ipw_pkg::*;

    localparam logic [15:0] CFG_HI = 16'h0040; // Arbitrary value
    localparam logic [15:0] DCYL = 16'h0100;
    localparam logic [7:0] DHD = 8'h10;
    localparam logic [7:0] DSPT = 8'h3F;
    localparam logic [7:0] MMAX = 8'h01;
    localparam logic [159:0] SER = "SN0000000001";
    localparam int SLEN = 12;
    localparam logic [63:0] FWP = "REV1    "; // Left-aligned, space padded
    localparam logic [319:0] MODL = "FLASH STORAGE CARD";
    localparam int MLEN = 18;
    localparam logic [31:0] TOT = DCYL * DHD * DSPT;

    logic ref_clk;
    logic reset;
    ipw_avm_req_s avm_req;
    ipw_avm_rsp_s avm_rsp;
    int miscompares;
    int n_tests;
    int cycles;

    ipw_identify #(.CFG_HIGH(CFG_HI), .DEF_CYL(DCYL), .DEF_HEADS(DHD), .DEF_SPT(DSPT),
        .MULT_MAX(MMAX), .DMA_MAX(2'h2), .ADV_PIO(1'b0), .SERIAL_TEXT(SER),
        .FW_TEXT("REV1"), .MODEL_TEXT(MODL)) dut_u (
        .ref_clk(ref_clk),
        .reset(reset),
        .avm_req(avm_req),
        .avm_rsp(avm_rsp)
    );

    ipw_host_model host_u (
        .ref_clk(ref_clk),
        .avm_rsp(avm_rsp),
        .avm_req(avm_req)
    );

    // Clock and cycle ceiling against hangs
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // Serial is right-aligned, model left-aligned, both space padded
    function automatic logic [7:0] sbyte(input int k);
        return (k >= 20 - SLEN) ? SER[8*(19-k) +: 8] : 8'h20;
    endfunction
    function automatic logic [7:0] mbyte(input int k);
        return (k < MLEN) ? MODL[8*(MLEN-1-k) +: 8] : 8'h20;
    endfunction

    // Expected identify word from control, geometry and mode settings
    function automatic logic [15:0] exp_word(input int n, input logic [3:0] ctl,
                                             input logic [31:0] chs, input logic [31:0] md);
        logic [31:0] cap;
        cap = chs[15:0] * chs[23:16] * chs[31:24];
        case (n)
            0: return {CFG_HI[15:6], ctl[1] ? 6'h0A : 6'h00};
            1: return DCYL;
            3: return {8'h00, DHD};
            6: return {8'h00, DSPT};
            7: return TOT[31:16];
            8: return TOT[15:0];
            22: return 16'h0004;
            47: return {8'h80, MMAX};
            49: return {2'b00, ctl[2], 1'b0, ctl[3], 3'b010, 8'h00};
            51: return {6'h00, md[19:18], 8'h00};
            53: return 16'h0001;
            54: return chs[15:0];
            55: return {8'h00, chs[23:16]};
            56: return {8'h00, chs[31:24]};
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {8'h01, md[7:0]};
            60: return TOT[15:0];
            61: return TOT[31:16];
            63: return {md[17:16] == 2'h3 ? 8'h00 : 8'h01 << md[17:16], 8'h07};
            default: begin
                if (n >= 10 && n <= 19) return {sbyte(2*n-20), sbyte(2*n-19)};
                if (n >= 23 && n <= 26) return FWP[63-16*(n-23) -: 16];
                if (n >= 27 && n <= 46) return {mbyte(2*n-54), mbyte(2*n-53)};
                return 16'h0000;
            end
        endcase
    endfunction

    // Bus helpers on top of the host model
    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        host_u.xfer(1'b1, adr, wd, d);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        host_u.xfer(1'b0, adr, 32'h0, d);
        `CHK(d, exp)
    endtask

    // Start a transfer and read all 256 words in order
    task automatic identify(input logic [3:0] ctl, input logic [31:0] chs,
                            input logic [31:0] md);
        logic [31:0] d;
        wr(IPW_OFF_CTRL, {28'h0, ctl} | 32'h1);
        rd_chk(IPW_OFF_STATUS, 32'h0001_0000);
        for (int n = 0; n < 256; n++) begin
            host_u.xfer(1'b0, IPW_OFF_DATA, 32'h0, d);
            `CHK(d, {16'h0000, exp_word(n, ctl, chs, md)})
        end
        rd_chk(IPW_OFF_STATUS, 32'h0);
        rd_chk(IPW_OFF_DATA, 32'h0);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        ref_clk = 1'b0;
        reset = 1'b1;
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk(IPW_OFF_CTRL, 32'h0000_0008);
        rd_chk(IPW_OFF_CUR_CHS, 32'h3F10_0100);
        rd_chk(IPW_OFF_MODES, 32'h0003_0000);
        rd_chk(8'h14, 32'h0);
        rd_chk(IPW_OFF_DATA, 32'h0);
        identify(4'h0, 32'h3F10_0100, 32'h0003_0000);
        wr(IPW_OFF_CUR_CHS, 32'h2008_0200);
        wr(IPW_OFF_MODES, 32'h000A_0002);
        rd_chk(IPW_OFF_MODES, 32'h000A_0000);
        wr(IPW_OFF_MODES, 32'h000E_0001);
        rd_chk(IPW_OFF_MODES, 32'h000A_0001);
        wr(8'h14, 32'hFFFF_FFFF);
        rd_chk(IPW_OFF_CUR_CHS, 32'h2008_0200);
        // Start after the finished transfer must begin again at word 0
        wr(IPW_OFF_CTRL, 32'h1);
        host_u.xfer(1'b0, IPW_OFF_DATA, 32'h0, d);
        `CHK(d, {16'h0000, CFG_HI[15:6], 6'h00})
        host_u.xfer(1'b0, IPW_OFF_DATA, 32'h0, d);
        `CHK(d, {16'h0000, DCYL})
        for (int m = 0; m < 3; m++) begin
            wr(IPW_OFF_MODES, 32'h1 | (m << 16) | (m << 18));
            identify(4'(6 + 4 * m), 32'h2008_0200, 32'h1 | (m << 16) | (m << 18));
        end
        wrap_up();
    end
endmodule
